/* File: hdl/pmcs_consts.vh */
// Constants for the power mode and clock select block.
`ifndef PMCS_CONSTS_VH
`define PMCS_CONSTS_VH
`define PMCS_SRC_OSC12 3'h0
`define PMCS_SRC_XTAL 3'h1
`define PMCS_SRC_OSC1M 3'h2
`define PMCS_SRC_RTC 3'h3
`define PMCS_SRC_NONE 3'h7
`define PMCS_MAIN_RESET_SRC 3'h0
`define PMCS_MODE_ACTIVE 3'h0
`define PMCS_MODE_SLEEP 3'h1
`define PMCS_MODE_DSLEEP 3'h2
`define PMCS_MODE_PDOWN 3'h3
`define PMCS_MODE_DPDOWN 3'h4
`define PMCS_WK_RESET 0
`define PMCS_WK_PIN_INT 1
`define PMCS_WK_GROUP_INT 2
`define PMCS_WK_OS_TIMER 3
`define PMCS_WK_STD_TIMER 4
`define PMCS_WK_MICRO_TICK 5
`define PMCS_WK_RTC_ALARM 6
`define PMCS_WK_WATCHDOG 7
`define PMCS_WK_BROWNOUT 8
`define PMCS_WK_USB 9
`define PMCS_WK_SERIAL 10
`define PMCS_WK_SERIAL3 11
`define PMCS_WK_COMPARATOR 12
`define PMCS_WK_PROG_LOGIC 13
`define PMCS_WK_WAKE_PIN 14
`define PMCS_WK_IRQ 15
`define PMCS_WK_W 16
`define PMCS_MASK_SLEEP 16'hFFFF
`define PMCS_MASK_DSLEEP 16'h3FFF
`define PMCS_MASK_PDOWN 16'h184D
`define PMCS_MASK_DPDOWN 16'h4049
`define PMCS_FLASH_WAKE_NS 100
`define PMCS_CLK_NS 10
`endif

/* File: hdl/pmcs_glitch_free_mux.v */
// Glitch-free select between two running clocks with a synchronised handover.
`timescale 1ns/1ps
module pmcs_glitch_free_mux (
  ref_clk,
  sys_rst,
  src_a,
  src_b,
  sel_b,
  clk_out,
  using_b
);
  input wire ref_clk;
  input wire sys_rst;
  input wire src_a;
  input wire src_b;
  input wire sel_b;
  output wire clk_out;
  output reg using_b;
  reg en_a_meta;
  reg en_a;
  reg en_b_meta;
  reg en_b;

  // Each enable only rises after the other side has fallen, so the output never carries both sources at once;
  // the enables step on ref_clk alone, so a source pulse can be cut short, but the handover finishes even if a source stops.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      en_a_meta <= 1'b1;
      en_a <= 1'b1;
      en_b_meta <= 1'b0;
      en_b <= 1'b0;
      using_b <= 1'b0;
    end else begin
      en_a_meta <= ~sel_b & ~en_b;
      en_a <= en_a_meta;
      en_b_meta <= sel_b & ~en_a;
      en_b <= en_b_meta;
      using_b <= en_b;
    end
  end

  assign clk_out = (src_a & en_a) | (src_b & en_b);
endmodule

/* File: hdl/pmcs_power_mode_ctrl.v */
// Power mode sequencer with clock source selection and supply drop handling.
// Notes on behaviour
// - Each frequency synth picks reference from 12 MHz, crystal, 1 MHz or RTC osc.
// - Each frequency synth has its own software enable.
// - Synchronised multiplexer switches only while old and new clocks both run; here the handover steps on ref_clk and finishes either way.
// - Unsynchronised multiplexers need the following divider halted while switching.
// - Each synth reference multiplexer offers a tied-off source for unused outputs; the main multiplexer has none.
// - High oscillator runs at 96 MHz; low output is a 12 MHz divide-down.
// - RTC oscillator clock reaches the tree only once its enable is set.
// - Supply drop below threshold raises an interrupt or a reset, as configured.
// - Sleep stops both core clocks; selected peripherals keep running.
// - Deep-sleep powers flash down, stops cores, gates unselected peripherals.
// - Deep-sleep ends on reset, pins, timers, alarm, watchdog, brownout or peripherals.
// - Deep-sleep keeps SRAM, GPIO state and registers.
// - SRAM not set for retention stays active in low-power modes.
// - Power-down ends on reset, group pins, OS timer, alarm, serial 3 or comparator.
// - Power-down retains primary core state.
// - Power-down holds no GPIO levels; all pins read zero.
// - Power-down keeps only pin config, serial 3, group int, RTC, timer, comparator.
// - Deep power-down keeps only RTC domain, reset pin, wake pins, optional OS timer; here SRAM banks also stay retained or active.
// - Deep power-down ends on reset pin, alarm, wake pin or OS timer time-out.
// - One-hertz alarm flag raises an RTC wake request able to leave deep power-down.
// - Deep power-down drives every functional pin high impedance.
// - Main clock comes from the 12 MHz oscillator after reset.
`timescale 1ns/1ps
`include "pmcs_consts.vh"
module pmcs_power_mode_ctrl #(
  parameter NUM_PERIPH = 8,
  parameter NUM_SRAM = 6,
  parameter NUM_PINS = 16,
  parameter FLASH_WAKE_NS = `PMCS_FLASH_WAKE_NS
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire internal_osc_low_out,
  input wire xtal_clk,
  input wire low_power_osc_out,
  input wire rtc_osc_clock,
  input wire rtc_osc_control,
  input wire [2:0] first_freq_synth_src,
  input wire [2:0] second_freq_synth_src,
  input wire first_freq_synth_en,
  input wire second_freq_synth_en,
  output wire first_synth_ref,
  output wire second_synth_ref,
  output reg first_freq_synth_on,
  output reg second_freq_synth_on,
  input wire main_sel_b,
  input wire main_src_b,
  output wire main_clk,
  output wire main_using_b,
  output reg internal_osc_high_on,
  output reg [2:0] internal_osc_div,
  input wire [2:0] mode_req,
  input wire mode_go,
  input wire [NUM_PERIPH-1:0] periph_keep,
  input wire os_timer_keep,
  input wire [NUM_SRAM-1:0] sram_retain,
  input wire [`PMCS_WK_W-1:0] wake_src,
  input wire one_hertz_alarm_flag,
  input wire supply_drop_detector,
  input wire drop_reset_mode,
  output reg drop_irq,
  output reg drop_reset,
  output reg [2:0] mode_state,
  output reg primary_core_clk_en,
  output reg secondary_core_clk_en,
  output reg primary_core_retain,
  output reg [NUM_PERIPH-1:0] periph_clk_en,
  output reg flash_power_en,
  output reg dcdc_en,
  output reg [NUM_SRAM-1:0] sram_active,
  output reg [NUM_SRAM-1:0] sram_retention,
  output reg reg_keep_all,
  output reg reg_keep_pdown_set,
  output reg gpio_hold,
  input wire [NUM_PINS-1:0] gpio_out_in,
  input wire [NUM_PINS-1:0] gpio_oe_in,
  output reg [NUM_PINS-1:0] gpio_out,
  output reg [NUM_PINS-1:0] gpio_oe,
  output reg os_timer_power,
  output reg wake_event
);

  localparam integer FLASH_WAKE_CYC = (FLASH_WAKE_NS + `PMCS_CLK_NS - 1) / `PMCS_CLK_NS;
  localparam [7:0] FLASH_WAKE_CNT = FLASH_WAKE_CYC < 1 ? 8'h01 : FLASH_WAKE_CYC[7:0];
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_LOW = 2'h1;
  localparam [1:0] ST_POWER_UP = 2'h2;
  localparam [1:0] ST_CLOCK_UP = 2'h3;

  reg [1:0] state;
  reg [7:0] wait_cnt;
  reg [`PMCS_WK_W-1:0] wake_meta;
  reg [`PMCS_WK_W-1:0] wake_sync;
  reg [1:0] alarm_sync;
  reg [1:0] drop_sync;
  reg [1:0] rtc_en_sync;
  reg gated_rtc;
  reg [`PMCS_WK_W-1:0] wake_vec;
  reg [`PMCS_WK_W-1:0] wake_mask;
  reg [1:0] next_state;

  // Unsynchronised source select; a glitch-free change needs the divider halted.
  function pick_src;
    input [2:0] sel;
    input osc12;
    input xtal;
    input osc1m;
    input rtc;
    begin
      case (sel)
        `PMCS_SRC_OSC12: pick_src = osc12;
        `PMCS_SRC_XTAL: pick_src = xtal;
        `PMCS_SRC_OSC1M: pick_src = osc1m;
        `PMCS_SRC_RTC: pick_src = rtc;
        default: pick_src = 1'b0;
      endcase
    end
  endfunction

  function [`PMCS_WK_W-1:0] mode_wake_mask;
    input [2:0] mode;
    begin
      case (mode)
        `PMCS_MODE_SLEEP: mode_wake_mask = `PMCS_MASK_SLEEP;
        `PMCS_MODE_DSLEEP: mode_wake_mask = `PMCS_MASK_DSLEEP;
        `PMCS_MODE_PDOWN: mode_wake_mask = `PMCS_MASK_PDOWN;
        `PMCS_MODE_DPDOWN: mode_wake_mask = `PMCS_MASK_DPDOWN;
        default: mode_wake_mask = {`PMCS_WK_W{1'b0}};
      endcase
    end
  endfunction

  // The RTC clock is combinationally gated by a synchronised enable level.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rtc_en_sync <= 2'h0;
      gated_rtc <= 1'b0;
    end else begin
      rtc_en_sync <= {rtc_en_sync[0], rtc_osc_control};
      gated_rtc <= rtc_en_sync[1];
    end
  end

  assign first_synth_ref = pick_src(first_freq_synth_src, internal_osc_low_out, xtal_clk, low_power_osc_out,
    rtc_osc_clock & gated_rtc);
  assign second_synth_ref = pick_src(second_freq_synth_src, internal_osc_low_out, xtal_clk, low_power_osc_out,
    rtc_osc_clock & gated_rtc);

  pmcs_glitch_free_mux u_main_mux (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .src_a(internal_osc_low_out),
    .src_b(main_src_b),
    .sel_b(main_sel_b),
    .clk_out(main_clk),
    .using_b(main_using_b)
  );

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_meta <= {`PMCS_WK_W{1'b0}};
      wake_sync <= {`PMCS_WK_W{1'b0}};
      alarm_sync <= 2'h0;
      drop_sync <= 2'h0;
    end else begin
      wake_meta <= wake_src;
      wake_sync <= wake_meta;
      alarm_sync <= {alarm_sync[0], one_hertz_alarm_flag};
      drop_sync <= {drop_sync[0], supply_drop_detector};
    end
  end

  always @* begin
    wake_vec = wake_sync;
    wake_vec[`PMCS_WK_RTC_ALARM] = wake_sync[`PMCS_WK_RTC_ALARM] | alarm_sync[1];
    wake_vec[`PMCS_WK_BROWNOUT] = wake_sync[`PMCS_WK_BROWNOUT] | drop_sync[1];
    wake_mask = mode_wake_mask(mode_state);
    if (mode_state == `PMCS_MODE_DPDOWN && !os_timer_keep) begin
      wake_mask[`PMCS_WK_OS_TIMER] = 1'b0;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (mode_go && mode_req != `PMCS_MODE_ACTIVE && mode_req <= `PMCS_MODE_DPDOWN) begin
          next_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (|(wake_vec & wake_mask)) begin
          next_state = ST_POWER_UP;
        end
      end
      ST_POWER_UP: begin
        if (wait_cnt == 8'h00) begin
          next_state = ST_CLOCK_UP;
        end
      end
      ST_CLOCK_UP: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_RUN;
      mode_state <= `PMCS_MODE_ACTIVE;
      wait_cnt <= 8'h00;
      wake_event <= 1'b0;
    end else begin
      state <= next_state;
      wake_event <= (state == ST_LOW) && (next_state == ST_POWER_UP);
      if (state == ST_RUN && next_state == ST_LOW) begin
        mode_state <= mode_req;
      end else if (state == ST_CLOCK_UP) begin
        mode_state <= `PMCS_MODE_ACTIVE;
      end
      if (state == ST_LOW) begin
        wait_cnt <= FLASH_WAKE_CNT;
      end else if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
    end
  end

  // Outputs follow the mode; power comes back in ST_POWER_UP, clocks one step later.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      primary_core_clk_en <= 1'b1;
      secondary_core_clk_en <= 1'b1;
      primary_core_retain <= 1'b0;
      periph_clk_en <= {NUM_PERIPH{1'b1}};
      flash_power_en <= 1'b1;
      dcdc_en <= 1'b1;
      sram_active <= {NUM_SRAM{1'b1}};
      sram_retention <= {NUM_SRAM{1'b0}};
      reg_keep_all <= 1'b1;
      reg_keep_pdown_set <= 1'b1;
      gpio_hold <= 1'b1;
      gpio_out <= {NUM_PINS{1'b0}};
      gpio_oe <= {NUM_PINS{1'b0}};
      os_timer_power <= 1'b1;
      first_freq_synth_on <= 1'b0;
      second_freq_synth_on <= 1'b0;
      internal_osc_high_on <= 1'b1;
      internal_osc_div <= 3'h0;
      drop_irq <= 1'b0;
      drop_reset <= 1'b0;
    end else begin
      internal_osc_high_on <= 1'b1;
      internal_osc_div <= internal_osc_div + 3'h1;
      drop_irq <= drop_sync[1] & ~drop_reset_mode;
      drop_reset <= drop_sync[1] & drop_reset_mode;
      gpio_out <= gpio_out_in;
      gpio_oe <= gpio_oe_in;
      if (state == ST_LOW) begin
        primary_core_clk_en <= 1'b0;
        secondary_core_clk_en <= 1'b0;
        first_freq_synth_on <= 1'b0;
        second_freq_synth_on <= 1'b0;
        case (mode_state)
          `PMCS_MODE_SLEEP: begin
            periph_clk_en <= periph_keep;
          end
          `PMCS_MODE_DSLEEP: begin
            flash_power_en <= 1'b0;
            periph_clk_en <= periph_keep;
            reg_keep_all <= 1'b1;
            gpio_hold <= 1'b1;
            sram_retention <= sram_retain;
            sram_active <= ~sram_retain;
          end
          `PMCS_MODE_PDOWN: begin
            flash_power_en <= 1'b0;
            dcdc_en <= 1'b0;
            periph_clk_en <= periph_keep;
            primary_core_retain <= 1'b1;
            gpio_hold <= 1'b0;
            gpio_out <= {NUM_PINS{1'b0}};
            reg_keep_all <= 1'b0;
            reg_keep_pdown_set <= 1'b1;
            sram_retention <= sram_retain;
            sram_active <= ~sram_retain;
          end
          `PMCS_MODE_DPDOWN: begin
            flash_power_en <= 1'b0;
            dcdc_en <= 1'b0;
            periph_clk_en <= {NUM_PERIPH{1'b0}};
            reg_keep_all <= 1'b0;
            reg_keep_pdown_set <= 1'b0;
            gpio_hold <= 1'b0;
            gpio_out <= {NUM_PINS{1'b0}};
            gpio_oe <= {NUM_PINS{1'b0}};
            os_timer_power <= os_timer_keep;
            sram_retention <= sram_retain;
            sram_active <= ~sram_retain;
          end
          default: begin
            periph_clk_en <= periph_keep;
          end
        endcase
      end else if (state == ST_POWER_UP) begin
        dcdc_en <= 1'b1;
        flash_power_en <= 1'b1;
        os_timer_power <= 1'b1;
        sram_active <= {NUM_SRAM{1'b1}};
        sram_retention <= {NUM_SRAM{1'b0}};
        reg_keep_all <= 1'b1;
        reg_keep_pdown_set <= 1'b1;
        gpio_hold <= 1'b1;
        gpio_oe <= {NUM_PINS{1'b0}};
        gpio_out <= {NUM_PINS{1'b0}};
      end else begin
        primary_core_clk_en <= 1'b1;
        secondary_core_clk_en <= 1'b1;
        primary_core_retain <= 1'b0;
        periph_clk_en <= {NUM_PERIPH{1'b1}};
        first_freq_synth_on <= first_freq_synth_en;
        second_freq_synth_on <= second_freq_synth_en;
      end
    end
  end
endmodule

/* File: tb/pmcs_checker.sv */
// Concurrent checks on the ports of the power mode controller.
`timescale 1ns/1ps
module pmcs_chk #(
  parameter NUM_PINS = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic internal_osc_low_out,
  input wire logic xtal_clk,
  input wire logic low_power_osc_out,
  input wire logic rtc_osc_control,
  input wire logic [2:0] first_freq_synth_src,
  input wire logic first_freq_synth_en,
  input wire logic first_synth_ref,
  input wire logic first_freq_synth_on,
  input wire logic main_using_b,
  input wire logic [2:0] mode_state,
  input wire logic primary_core_clk_en,
  input wire logic secondary_core_clk_en,
  input wire logic primary_core_retain,
  input wire logic flash_power_en,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  input wire logic supply_drop_detector,
  input wire logic drop_reset_mode,
  input wire logic drop_irq,
  input wire logic drop_reset,
  input wire logic wake_event
);
  wire [2:0] s = first_freq_synth_src;
  // The RTC code is left out here because its gate lags the enable by the synchroniser.
  wire want_ref = s == 3'h0 ? internal_osc_low_out : s == 3'h1 ? xtal_clk : s == 3'h2 ? low_power_osc_out : 1'b0;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  src_select_a:
    assert property (s != 3'h3 |-> first_synth_ref == want_ref) else $error("synth reference source wrong");
  rtc_gate_a:
    assert property ((!rtc_osc_control)[*4] ##0 s == 3'h3 |-> !first_synth_ref) else $error("rtc clock leaks");
  synth_follow_a:
    assert property (mode_state == 3'h0 && $past(mode_state) == 3'h0 && !$past(sys_rst)
      |-> first_freq_synth_on == $past(first_freq_synth_en)) else $error("synth enable not followed");
  reset_main_a:
    assert property ($fell(sys_rst) |-> !main_using_b && mode_state == 3'h0) else $error("bad state after reset");
  sleep_cores_a:
    assert property (mode_state == 3'h0 ##1 mode_state == 3'h1 |=> !primary_core_clk_en && !secondary_core_clk_en)
    else $error("cores clocked in sleep");
  dsleep_flash_a:
    assert property (mode_state == 3'h0 ##1 mode_state == 3'h2 |=> !flash_power_en && !primary_core_clk_en)
    else $error("flash on in deep sleep");
  pdown_gpio_a:
    assert property (mode_state == 3'h0 ##1 mode_state == 3'h3 |=> gpio_out == 0 && primary_core_retain)
    else $error("power-down pins or core state wrong");
  dpdown_hiz_a:
    assert property (mode_state == 3'h0 ##1 mode_state == 3'h4 |=> gpio_oe == 0) else $error("pins driven");
  drop_route_a:
    assert property ((supply_drop_detector && $stable(drop_reset_mode))[*5]
      |-> drop_reset == drop_reset_mode && drop_irq == !drop_reset_mode) else $error("drop routed wrongly");
  drop_clear_a:
    assert property ((!supply_drop_detector)[*5] |-> !drop_irq && !drop_reset) else $error("drop stuck");
  wake_return_a:
    assert property (wake_event |-> ##[1:20] mode_state == 3'h0) else $error("no return to active");
endmodule

bind pmcs_power_mode_ctrl pmcs_chk #(.NUM_PINS(NUM_PINS)) u_chk (.ref_clk, .sys_rst, .internal_osc_low_out,
  .xtal_clk, .low_power_osc_out, .rtc_osc_control, .first_freq_synth_src, .first_freq_synth_en, .first_synth_ref,
  .first_freq_synth_on, .main_using_b, .mode_state, .primary_core_clk_en, .secondary_core_clk_en,
  .primary_core_retain, .flash_power_en, .gpio_out, .gpio_oe, .supply_drop_detector, .drop_reset_mode,
  .drop_irq, .drop_reset, .wake_event);

/* File: tb/tb_top.sv */
// Self-checking bench for the power mode controller.
`timescale 1ns/1ps
`include "pmcs_consts.vh"
module tb_top;
  logic ref_clk = 0, sys_rst = 1, internal_osc_low_out = 0, xtal_clk = 0, low_power_osc_out = 0;
  logic rtc_osc_clock = 0, rtc_osc_control = 0, first_freq_synth_en = 0, second_freq_synth_en = 0;
  logic main_sel_b = 0, main_src_b = 1, mode_go = 0, os_timer_keep = 0, one_hertz_alarm_flag = 0;
  logic supply_drop_detector = 0, drop_reset_mode = 0;
  logic [2:0] first_freq_synth_src = 0, second_freq_synth_src = 0, mode_req = 0;
  logic [7:0] periph_keep = 0;
  logic [5:0] sram_retain = 0;
  logic [15:0] wake_src = 0, gpio_out_in = 0, gpio_oe_in = 0;
  logic [2:0] last_div;
  wire first_synth_ref, second_synth_ref, first_freq_synth_on, second_freq_synth_on, main_clk, main_using_b;
  wire internal_osc_high_on, drop_irq, drop_reset, primary_core_clk_en, secondary_core_clk_en, wake_event;
  wire primary_core_retain, flash_power_en, dcdc_en, reg_keep_all, reg_keep_pdown_set, gpio_hold, os_timer_power;
  wire [2:0] internal_osc_div, mode_state;
  wire [7:0] periph_clk_en;
  wire [5:0] sram_active, sram_retention;
  wire [15:0] gpio_out, gpio_oe;
  int fails = 0, samples_checked = 0;

  pmcs_power_mode_ctrl dut (.ref_clk, .sys_rst, .internal_osc_low_out, .xtal_clk, .low_power_osc_out,
    .rtc_osc_clock, .rtc_osc_control, .first_freq_synth_src, .second_freq_synth_src, .first_freq_synth_en,
    .second_freq_synth_en, .first_synth_ref, .second_synth_ref, .first_freq_synth_on, .second_freq_synth_on,
    .main_sel_b, .main_src_b, .main_clk, .main_using_b, .internal_osc_high_on, .internal_osc_div, .mode_req,
    .mode_go, .periph_keep, .os_timer_keep, .sram_retain, .wake_src, .one_hertz_alarm_flag, .supply_drop_detector,
    .drop_reset_mode, .drop_irq, .drop_reset, .mode_state, .primary_core_clk_en, .secondary_core_clk_en,
    .primary_core_retain, .periph_clk_en, .flash_power_en, .dcdc_en, .sram_active, .sram_retention, .reg_keep_all,
    .reg_keep_pdown_set, .gpio_hold, .gpio_out_in, .gpio_oe_in, .gpio_out, .gpio_oe, .os_timer_power, .wake_event);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Source clocks keep running so the glitch-free handover always has both sides alive.
  always @(negedge ref_clk) begin
    internal_osc_low_out <= ~internal_osc_low_out;
    main_src_b <= ~main_src_b;
    {xtal_clk, low_power_osc_out, rtc_osc_clock} <= 3'($urandom);
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  function automatic logic ref_of(input logic [2:0] s);
    case (s)
      3'h0: ref_of = internal_osc_low_out;
      3'h1: ref_of = xtal_clk;
      3'h2: ref_of = low_power_osc_out;
      3'h3: ref_of = rtc_osc_clock & rtc_osc_control;
      default: ref_of = 1'b0;
    endcase
  endfunction

  task automatic go(input logic [2:0] m);
    mode_req = m;
    mode_go = 1;
    tick(1);
    mode_go = 0;
    tick(3);
  endtask

  task automatic run_mode(input logic [2:0] m, input logic alarm);
    logic [15:0] msk;
    int b;
    int n;
    logic seen_wake;
    msk = m == 3'h1 ? 16'hFFFF : m == 3'h2 ? `PMCS_MASK_DSLEEP : m == 3'h3 ? `PMCS_MASK_PDOWN : `PMCS_MASK_DPDOWN;
    if (m == 3'h4 && !os_timer_keep) msk[`PMCS_WK_OS_TIMER] = 1'b0;
    go(m);
    chk("mode_state", mode_state, m);
    case (m)
      3'h1: chk("cores", {primary_core_clk_en, secondary_core_clk_en}, 0);
      3'h2: begin
        chk("flash", {flash_power_en, primary_core_clk_en, secondary_core_clk_en}, 0);
        chk("periph", periph_clk_en, periph_keep);
        chk("retention", sram_retention, sram_retain);
        chk("sram", sram_active | sram_retain, 6'h3F);
        chk("keep", {reg_keep_all, gpio_hold}, 2'h3);
      end
      3'h3: begin
        chk("gpio", gpio_out, 0);
        chk("retain", primary_core_retain, 1);
        chk("keep", reg_keep_pdown_set, 1);
      end
      default: begin
        chk("oe", gpio_oe, 0);
        chk("power", {dcdc_en, flash_power_en, os_timer_power}, {2'h0, os_timer_keep});
      end
    endcase
    // Sleep accepts every source, so only the deeper modes get a source that must be ignored.
    if (msk != 16'hFFFF) begin
      do b = $urandom % 16; while (msk[b]);
      wake_src[b] = 1;
      tick(8);
      chk("no_wake", mode_state, m);
      wake_src = 0;
    end
    if (alarm) one_hertz_alarm_flag = 1;
    else begin
      do b = $urandom % 16; while (!msk[b]);
      wake_src[b] = 1;
    end
    seen_wake = 0;
    n = 0;
    while (mode_state !== 3'h0 && n < 40) begin
      tick(1);
      n++;
      seen_wake |= wake_event;
    end
    wake_src = 0;
    one_hertz_alarm_flag = 0;
    chk("woke", {seen_wake, mode_state}, 4'h8);
    tick(1);
    chk("restored", {primary_core_clk_en, secondary_core_clk_en, flash_power_en}, 3'h7);
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(53));
    tick(4);
    sys_rst = 0;
    chk("reset", {main_using_b, mode_state, sram_active}, 10'h03F);
    rtc_osc_control = 1;
    gpio_oe_in = 16'hFFFF;
    gpio_out_in = 16'hA5A5;
    tick(4);
    for (int s = 0; s < 8; s++) begin
      first_freq_synth_src = 3'(s);
      second_freq_synth_src = 3'(7 - s);
      repeat (3) begin
        first_freq_synth_en = 1'($urandom);
        second_freq_synth_en = ~first_freq_synth_en;
        last_div = internal_osc_div;
        tick(1);
        #1;
        chk("div", {internal_osc_high_on, internal_osc_div}, {1'b1, last_div + 3'h1});
        chk("ref1", first_synth_ref, ref_of(first_freq_synth_src));
        chk("ref2", second_synth_ref, ref_of(second_freq_synth_src));
        chk("on", {first_freq_synth_on, second_freq_synth_on}, {first_freq_synth_en, second_freq_synth_en});
      end
    end
    rtc_osc_control = 0;
    first_freq_synth_src = 3'h3;
    tick(5);
    repeat (4) begin
      tick(1);
      #1;
      chk("rtc_off", first_synth_ref, 0);
    end
    for (int v = 1; v >= 0; v--) begin
      main_sel_b = 1'(v);
      for (int n = 0; n < 30 && main_using_b !== 1'(v); n++) tick(1);
      chk("using_b", main_using_b, v);
      // The 12 MHz side is enabled again one edge after the handover flag drops.
      tick(2);
      #1;
      chk("main_clk", main_clk, v ? main_src_b : internal_osc_low_out);
    end
    for (int r = 0; r < 8; r++) begin
      if (r == 0 || r > 4) begin
        go(3'(r));
        chk("refused", mode_state, 0);
      end
    end
    for (int i = 0; i < 2; i++) begin
      drop_reset_mode = 1'(i);
      supply_drop_detector = 1;
      tick(5);
      chk("drop", {drop_reset, drop_irq}, i ? 2'h2 : 2'h1);
      supply_drop_detector = 0;
      tick(5);
      chk("drop_off", {drop_reset, drop_irq}, 0);
    end
    for (int m = 1; m <= 4; m++) run_mode(3'(m), 0);
    run_mode(3'h4, 1);
    for (int k = 0; k < 10; k++) begin
      {periph_keep, sram_retain, os_timer_keep} = 15'($urandom);
      gpio_out_in = 16'($urandom) | 16'h0001;
      run_mode(3'(1 + $urandom % 4), 0);
    end
    tally_and_finish;
  end

  // The whole sequence needs about five hundred cycles; twenty thousand means a hang.
  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end
endmodule
